// ==== hdl/nand_copy_erase_pkg.sv ====
package nand_copy_erase_pkg;

  // ==========================================================================
  // Device command codes
  localparam logic [7:0] CMD_READ        = 8'h00;
  localparam logic [7:0] CMD_COPY_READ   = 8'h35;
  localparam logic [7:0] CMD_PROG_CONF   = 8'h10;
  localparam logic [7:0] CMD_RAND_IN     = 8'h85;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_EXEC  = 8'hd0;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_RESET       = 8'hff;

  // ==========================================================================
  // Controller operations written to the control register
  typedef enum logic [2:0] {
    OP_NONE     = 3'h0,
    OP_COPY_RD  = 3'h1,
    OP_DATA_IN  = 3'h2,
    OP_COPY_PG  = 3'h3,
    OP_ERASE    = 3'h4,
    OP_STATUS   = 3'h5,
    OP_RESUME   = 3'h6,
    OP_RESET    = 3'h7
  } op_t;

  typedef enum logic [2:0] {
    K_CMD  = 3'h0,
    K_ADDR = 3'h1,
    K_DATA = 3'h2,
    K_READ = 3'h3,
    K_WAIT = 3'h4,
    K_DONE = 3'h5
  } kind_t;

  typedef struct packed {
    kind_t      kind;
    logic [7:0] value;
  } step_t;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_CONFIG = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  localparam int BIT_BUSY   = 8;
  localparam int BIT_ERR    = 9;
  localparam int BIT_BOOTED = 10;
  localparam int BIT_WP_EN  = 0;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS        = 5;
  localparam int T_STROBE_NS          = 25;
  localparam int T_BUSY_DELAY_NS      = 100;
  localparam int T_STARTUP_US         = 200;
  localparam int SYNC_STAGES          = 2;
  localparam logic [15:0] STROBE_CYC  = 16'((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] BUSY_DLY_CYC = 16'((T_BUSY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] READ_CYC    = 16'(STROBE_CYC + 16'(SYNC_STAGES));
  localparam logic [15:0] STARTUP_CYC = 16'((T_STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [7:0] {
    ST_BOOT  = 8'h01,
    ST_IDLE  = 8'h02,
    ST_FETCH = 8'h04,
    ST_WLOW  = 8'h08,
    ST_WHIGH = 8'h10,
    ST_RLOW  = 8'h20,
    ST_RHIGH = 8'h40,
    ST_WAIT  = 8'h80
  } state_t;

endpackage : nand_copy_erase_pkg

// ==== hdl/nand_copy_erase_host.sv ====
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module nand_copy_erase_host
  import nand_copy_erase_pkg::*;
#(
  parameter logic [15:0] STARTUP_CYCLES = STARTUP_CYC
) (
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             COMMAND_LATCH,
  output logic             ADDRESS_LATCH,
  output logic             CHIP_SELECT_N,
  output logic             WRITE_STROBE_N,
  output logic             READ_STROBE_N,
  output logic             WRITE_PROTECT_N,
  output logic      [7:0]  IO_OUT,
  output logic             IO_OE,
  input  wire logic [7:0]  IO_IN,
  input  wire logic        READY_BUSY_N
);

  // ==========================================================================
  // State
  typedef struct packed {
    state_t      state;
    op_t         op;
    logic [3:0]  idx;
    logic [15:0] cnt;
    logic [15:0] col;
    logic [15:0] row;
    logic [7:0]  data;
    logic [7:0]  dev_status;
    logic        wp_en;
    logic        busy;
    logic        err;
    logic        booted;
    logic [7:0]  haddr;
    logic        wr_pend;
    logic        rd_pend;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        cle;
    logic        ale;
    logic        ce_n;
    logic        we_n;
    logic        re_n;
    logic [7:0]  io_out;
    logic        io_oe;
    logic [7:0]  io_m;
    logic [7:0]  io_s;
    logic        rb_m;
    logic        rb_s;
  } regs_t;

  regs_t s_r;
  regs_t s_nxt;
  step_t step;

  // ==========================================================================
  // Pin sequence of each operation
  function automatic step_t step_of(input op_t op, input logic [3:0] i, input logic [15:0] col,
                                    input logic [15:0] row, input logic [7:0] dat);
    step_t r;
    r = '{K_DONE, 8'h00};
    case (op)
      OP_COPY_RD: begin
        case (i)
          4'h0: r = '{K_CMD, CMD_READ};
          4'h1: r = '{K_ADDR, col[7:0]};
          4'h2: r = '{K_ADDR, col[15:8]};
          4'h3: r = '{K_ADDR, row[7:0]};
          4'h4: r = '{K_ADDR, row[15:8]};
          4'h5: r = '{K_CMD, CMD_COPY_READ};
          4'h6: r = '{K_WAIT, 8'h00};
          default: r = '{K_DONE, 8'h00};
        endcase
      end
      OP_DATA_IN: begin
        case (i)
          4'h0: r = '{K_CMD, CMD_RAND_IN};
          4'h1: r = '{K_ADDR, col[7:0]};
          4'h2: r = '{K_ADDR, col[15:8]};
          4'h3: r = '{K_DATA, dat};
          default: r = '{K_DONE, 8'h00};
        endcase
      end
      OP_COPY_PG: begin
        case (i)
          4'h0: r = '{K_CMD, CMD_RAND_IN};
          4'h1: r = '{K_ADDR, col[7:0]};
          4'h2: r = '{K_ADDR, col[15:8]};
          4'h3: r = '{K_ADDR, row[7:0]};
          4'h4: r = '{K_ADDR, row[15:8]};
          4'h5: r = '{K_CMD, CMD_PROG_CONF};
          4'h6: r = '{K_WAIT, 8'h00};
          4'h7: r = '{K_CMD, CMD_STATUS};
          4'h8: r = '{K_READ, 8'h00};
          default: r = '{K_DONE, 8'h00};
        endcase
      end
      OP_ERASE: begin
        // Full row is sent; the device itself drops the page bits
        case (i)
          4'h0: r = '{K_CMD, CMD_ERASE_SETUP};
          4'h1: r = '{K_ADDR, row[7:0]};
          4'h2: r = '{K_ADDR, row[15:8]};
          4'h3: r = '{K_CMD, CMD_ERASE_EXEC};
          4'h4: r = '{K_WAIT, 8'h00};
          4'h5: r = '{K_CMD, CMD_STATUS};
          4'h6: r = '{K_READ, 8'h00};
          default: r = '{K_DONE, 8'h00};
        endcase
      end
      OP_STATUS: begin
        case (i)
          4'h0: r = '{K_CMD, CMD_STATUS};
          4'h1: r = '{K_READ, 8'h00};
          default: r = '{K_DONE, 8'h00};
        endcase
      end
      OP_RESUME: begin
        // Leaves status mode; the device picks up at the old column
        case (i)
          4'h0: r = '{K_CMD, CMD_READ};
          default: r = '{K_DONE, 8'h00};
        endcase
      end
      OP_RESET: begin
        case (i)
          4'h0: r = '{K_CMD, CMD_RESET};
          4'h1: r = '{K_WAIT, 8'h00};
          default: r = '{K_DONE, 8'h00};
        endcase
      end
      default: r = '{K_DONE, 8'h00};
    endcase
    return r;
  endfunction : step_of

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    step  = step_of(s_r.op, s_r.idx, s_r.col, s_r.row, s_r.data);
    s_nxt.io_m = IO_IN;
    s_nxt.io_s = s_r.io_m;
    s_nxt.rb_m = READY_BUSY_N;
    s_nxt.rb_s = s_r.rb_m;

    case (s_r.state)
      ST_BOOT: begin
        // No command at all until power-up and any power-on read are over
        if (s_r.cnt < STARTUP_CYCLES) begin
          s_nxt.cnt = s_r.cnt + 16'h0001;
        end else if (s_r.rb_s) begin
          s_nxt.booted = 1'b1;
          s_nxt.state  = ST_IDLE;
        end
      end
      ST_IDLE: begin
        s_nxt.ce_n = 1'b1;
      end
      ST_FETCH: begin
        s_nxt.cnt = 16'h0000;
        case (step.kind)
          K_CMD, K_ADDR, K_DATA: begin
            s_nxt.ce_n   = 1'b0;
            s_nxt.cle    = (step.kind == K_CMD);
            s_nxt.ale    = (step.kind == K_ADDR);
            s_nxt.io_out = step.value;
            s_nxt.io_oe  = 1'b1;
            s_nxt.we_n   = 1'b0;
            s_nxt.state  = ST_WLOW;
          end
          K_READ: begin
            s_nxt.ce_n  = 1'b0;
            s_nxt.re_n  = 1'b0;
            s_nxt.state = ST_RLOW;
          end
          K_WAIT: begin
            // Select is dropped for the busy period
            s_nxt.ce_n  = 1'b1;
            s_nxt.state = ST_WAIT;
          end
          default: begin
            s_nxt.ce_n  = 1'b1;
            s_nxt.busy  = 1'b0;
            s_nxt.state = ST_IDLE;
          end
        endcase
      end
      ST_WLOW: begin
        s_nxt.cnt = s_r.cnt + 16'h0001;
        if (s_r.cnt >= STROBE_CYC - 16'h0001) begin
          s_nxt.we_n  = 1'b1;
          s_nxt.cnt   = 16'h0000;
          s_nxt.state = ST_WHIGH;
        end
      end
      ST_WHIGH: begin
        s_nxt.cnt = s_r.cnt + 16'h0001;
        if (s_r.cnt >= STROBE_CYC - 16'h0001) begin
          s_nxt.cle   = 1'b0;
          s_nxt.ale   = 1'b0;
          s_nxt.io_oe = 1'b0;
          s_nxt.idx   = s_r.idx + 4'h1;
          s_nxt.state = ST_FETCH;
        end
      end
      ST_RLOW: begin
        // Strobe time plus the input synchroniser delay
        s_nxt.cnt = s_r.cnt + 16'h0001;
        if (s_r.cnt >= READ_CYC - 16'h0001) begin
          s_nxt.dev_status = s_r.io_s;
          s_nxt.re_n       = 1'b1;
          s_nxt.cnt        = 16'h0000;
          s_nxt.state      = ST_RHIGH;
        end
      end
      ST_RHIGH: begin
        s_nxt.cnt = s_r.cnt + 16'h0001;
        if (s_r.cnt >= STROBE_CYC - 16'h0001) begin
          s_nxt.idx   = s_r.idx + 4'h1;
          s_nxt.state = ST_FETCH;
        end
      end
      ST_WAIT: begin
        // The pin only goes low some time after the last strobe
        if (s_r.cnt < BUSY_DLY_CYC) begin
          s_nxt.cnt = s_r.cnt + 16'h0001;
        end else if (s_r.rb_s) begin
          s_nxt.idx   = s_r.idx + 4'h1;
          s_nxt.state = ST_FETCH;
        end
      end
      default: begin
        s_nxt.state = ST_IDLE;
      end
    endcase

    // ========================================================================
    // AHB-Lite slave
    s_nxt.wr_pend = 1'b0;
    s_nxt.rd_pend = 1'b0;
    if (s_r.wr_pend) begin
      if (s_r.haddr == REG_CTRL) begin
        if (s_r.state == ST_IDLE && op_t'(HWDATA[2:0]) != OP_NONE) begin
          s_nxt.op    = op_t'(HWDATA[2:0]);
          s_nxt.idx   = 4'h0;
          s_nxt.busy  = 1'b1;
          s_nxt.err   = 1'b0;
          s_nxt.state = ST_FETCH;
        end else begin
          s_nxt.err = 1'b1;
        end
      end else if (s_r.haddr == REG_ADDR) begin
        s_nxt.col = HWDATA[15:0];
        s_nxt.row = HWDATA[31:16];
      end else if (s_r.haddr == REG_DATA) begin
        s_nxt.data = HWDATA[7:0];
      end else if (s_r.haddr == REG_CONFIG) begin
        // Protect level may change only between operations
        if (s_r.state == ST_IDLE) begin
          s_nxt.wp_en = HWDATA[BIT_WP_EN];
        end else begin
          s_nxt.err = 1'b1;
        end
      end
    end
    if (s_r.rd_pend) begin
      s_nxt.hreadyout = 1'b1;
      if (s_r.haddr == REG_CTRL) begin
        s_nxt.hrdata = {29'h0, s_r.op};
      end else if (s_r.haddr == REG_ADDR) begin
        s_nxt.hrdata = {s_r.row, s_r.col};
      end else if (s_r.haddr == REG_DATA) begin
        s_nxt.hrdata = {24'h0, s_r.data};
      end else if (s_r.haddr == REG_CONFIG) begin
        s_nxt.hrdata = {31'h0, s_r.wp_en};
      end else if (s_r.haddr == REG_STATUS) begin
        s_nxt.hrdata = 32'h0;
        s_nxt.hrdata[7:0]       = s_r.dev_status;
        s_nxt.hrdata[BIT_BUSY]  = s_r.busy;
        s_nxt.hrdata[BIT_ERR]   = s_r.err;
        s_nxt.hrdata[BIT_BOOTED] = s_r.booted;
      end else begin
        s_nxt.hrdata = 32'h0;
      end
    end
    if (HSEL && HTRANS[1] && HREADY) begin
      s_nxt.haddr   = HADDR[7:0];
      s_nxt.wr_pend = HWRITE;
      s_nxt.rd_pend = !HWRITE;
      if (!HWRITE) begin
        s_nxt.hreadyout = 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      s_r           <= '0;
      s_r.state     <= ST_BOOT;
      s_r.op        <= OP_NONE;
      s_r.hreadyout <= 1'b1;
      s_r.ce_n      <= 1'b1;
      s_r.we_n      <= 1'b1;
      s_r.re_n      <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign HRDATA          = s_r.hrdata;
  assign HREADYOUT       = s_r.hreadyout;
  assign HRESP           = s_r.hresp;
  assign COMMAND_LATCH   = s_r.cle;
  assign ADDRESS_LATCH   = s_r.ale;
  assign CHIP_SELECT_N   = s_r.ce_n;
  assign WRITE_STROBE_N  = s_r.we_n;
  assign READ_STROBE_N   = s_r.re_n;
  assign WRITE_PROTECT_N = s_r.wp_en;
  assign IO_OUT          = s_r.io_out;
  assign IO_OE           = s_r.io_oe;

endmodule : nand_copy_erase_host

// ==== verification/nand_copy_erase_host_assertions.sv ====
`timescale 1ns/1ps
module nand_copy_erase_host_checker (
  input wire logic       MCLK,
  input wire logic       RESETN,
  input wire logic       HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic       HWRITE,
  input wire logic       HREADY,
  input wire logic       HREADYOUT,
  input wire logic       HRESP,
  input wire logic       COMMAND_LATCH,
  input wire logic       ADDRESS_LATCH,
  input wire logic       CHIP_SELECT_N,
  input wire logic       WRITE_STROBE_N,
  input wire logic       READ_STROBE_N,
  input wire logic       WRITE_PROTECT_N,
  input wire logic [7:0] IO_OUT,
  input wire logic       IO_OE,
  input wire logic       READY_BUSY_N
);
  // ==========================================================================
  // Bus and link properties
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  property p_hresp; HRESP == 1'b0; endproperty
  a_hresp: assert property (p_hresp) else $error("bus error response");
  property p_rd_wait; HSEL && HTRANS[1] && HREADY && !HWRITE |=> !HREADYOUT ##1 HREADYOUT; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_nowait; HSEL && HTRANS[1] && HREADY && HWRITE |=> HREADYOUT; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_we_sel; !WRITE_STROBE_N |-> !CHIP_SELECT_N && IO_OE; endproperty
  a_we_sel: assert property (p_we_sel) else $error("write strobe without select");
  // A read strobe while the host drives the bus would fight the device
  property p_re_free; !READ_STROBE_N |-> !CHIP_SELECT_N && !IO_OE; endproperty
  a_re_free: assert property (p_re_free) else $error("read strobe with bus driven");
  property p_latch_excl; !(COMMAND_LATCH && ADDRESS_LATCH); endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("both latches high");
  property p_we_pulse; $fell(WRITE_STROBE_N) |-> !WRITE_STROBE_N [*5] ##1 WRITE_STROBE_N; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe width");
  property p_re_pulse; $fell(READ_STROBE_N) |-> !READ_STROBE_N [*7] ##1 READ_STROBE_N; endproperty
  a_re_pulse: assert property (p_re_pulse) else $error("read strobe width");
  property p_we_hold;
    !WRITE_STROBE_N && !$past(WRITE_STROBE_N) |-> $stable(IO_OUT) && $stable(COMMAND_LATCH) && $stable(ADDRESS_LATCH);
  endproperty
  a_we_hold: assert property (p_we_hold) else $error("cycle changed under strobe");
  property p_wp_hold; !CHIP_SELECT_N && !$past(CHIP_SELECT_N) |-> $stable(WRITE_PROTECT_N); endproperty
  a_wp_hold: assert property (p_wp_hold) else $error("protect pin moved mid operation");
  property p_cmd_ready; $fell(WRITE_STROBE_N) |-> READY_BUSY_N; endproperty
  a_cmd_ready: assert property (p_cmd_ready) else $error("write cycle while device busy");
endmodule : nand_copy_erase_host_checker

bind nand_copy_erase_host nand_copy_erase_host_checker u_chk (
  .MCLK(MCLK), .RESETN(RESETN), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .COMMAND_LATCH(COMMAND_LATCH), .ADDRESS_LATCH(ADDRESS_LATCH),
  .CHIP_SELECT_N(CHIP_SELECT_N), .WRITE_STROBE_N(WRITE_STROBE_N), .READ_STROBE_N(READ_STROBE_N),
  .WRITE_PROTECT_N(WRITE_PROTECT_N), .IO_OUT(IO_OUT), .IO_OE(IO_OE), .READY_BUSY_N(READY_BUSY_N));

// ==== verification/nand_dev_model.sv ====
`timescale 1ns/1ps
module nand_dev_model #(
  parameter int BUSY_NS   = 2000,
  parameter int POR_NS    = 500,
  parameter int PAGE_BITS = 6
) (
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       ce_n,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] din,
  output logic      [7:0] dout,
  output logic            rb_low
);
  logic        busy = 1'b1;
  logic        stat_mode = 1'b0;
  logic        fail = 1'b0;
  logic        armed = 1'b0;
  logic [15:0] row_q = '0;
  logic [7:0]  data_q = '0;
  logic [31:0] erase_blk = '0;
  int          n_erase = 0;
  int          n_copy = 0;
  int          n_prog = 0;
  int          n_bad = 0;
  logic        in_ser = 1'b0;
  wire  [7:0]  status = {wp_n, ~busy, ~busy, 4'h0, fail};
  wire  [7:0]  out_v = stat_mode ? status : data_q;

  // Released bus shows the inverse so a stale value never passes
  assign dout = (!ce_n && !re_n) ? out_v : ~out_v;
  assign rb_low = busy;
  initial #POR_NS busy = 1'b0;

  task automatic go_busy;
    busy = 1'b1;
    fork
      #BUSY_NS busy = 1'b0;
    join_none
  endtask : go_busy

  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      if (din != 8'h70) fail = 1'b0;
      stat_mode = (din == 8'h70);
      if (in_ser && !(din inside {8'h10, 8'h85, 8'hff})) n_bad++;
      in_ser = (din == 8'h85);
      case (din)
        8'h35: begin n_copy++; go_busy(); end
        8'h10: if (wp_n) begin n_prog++; go_busy(); end
        8'hd0: if (armed && wp_n) begin
          erase_blk = 32'(row_q >> PAGE_BITS);
          n_erase++;
          go_busy();
        end
        8'hff: go_busy();
        default: ;
      endcase
      armed = (din == 8'h60);
    end else if (!ce_n && ale) row_q = {din, row_q[15:8]};
    else if (!ce_n) data_q = din;
  end
endmodule : nand_dev_model

// ==== verification/tb_nand_copy_erase_host.sv ====
`timescale 1ns/1ps
module tb_nand_copy_erase_host;
  import nand_copy_erase_pkg::*;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, cle, ale, ce_n, we_n, re_n, wp_n, io_oe, rb_low;
  logic [7:0]  io_out, dev_io;
  int          n_errors = 0;
  int          samples_checked = 0;
  wire  [7:0]  io_bus = io_oe ? io_out : dev_io;

  always #2.5 mclk = ~mclk;

  nand_copy_erase_host #(.STARTUP_CYCLES(16'd16)) dut_u (
    .MCLK(mclk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .COMMAND_LATCH(cle), .ADDRESS_LATCH(ale), .CHIP_SELECT_N(ce_n),
    .WRITE_STROBE_N(we_n), .READ_STROBE_N(re_n), .WRITE_PROTECT_N(wp_n), .IO_OUT(io_out),
    .IO_OE(io_oe), .IO_IN(io_bus), .READY_BUSY_N(~rb_low));

  nand_dev_model u_dev (
    .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
    .din(io_bus), .dout(dev_io), .rb_low(rb_low));

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // Polls until the sequence is over; ends holding the status word in rd
  task automatic run_op(input op_t op);
    int i;
    ahb(1'b1, REG_CTRL, {29'h0, op});
    i = 0;
    do begin
      ahb(1'b0, REG_STATUS, 32'h0);
      i++;
    end while (rd[BIT_BUSY] !== 1'b0 && i < 1000);
  endtask : run_op

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // Scenarios
  task automatic t_boot;
    int i;
    ahb(1'b0, REG_CONFIG, 32'h0);
    check(rd, 32'h0);
    check({31'h0, wp_n}, 32'h0);
    ahb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    ahb(1'b1, REG_CTRL, {29'h0, OP_STATUS});
    ahb(1'b0, REG_STATUS, 32'h0);
    check({30'h0, rd[BIT_BOOTED:BIT_ERR]}, 32'h1);
    i = 0;
    do begin
      ahb(1'b0, REG_STATUS, 32'h0);
      i++;
    end while (rd[BIT_BOOTED] !== 1'b1 && i < 200);
    check({31'h0, rd[BIT_BOOTED]}, 32'h1);
    $display("boot test done");
  endtask : t_boot

  task automatic t_erase;
    ahb(1'b1, REG_CONFIG, 32'h1);
    // The pin updates at the edge that ends the write; look one edge later
    @(posedge mclk);
    check({31'h0, wp_n}, 32'h1);
    ahb(1'b1, REG_ADDR, 32'h04c7_0000);
    run_op(OP_ERASE);
    check({22'h0, rd[9:0]}, 32'he0);
    check(u_dev.erase_blk, 32'h04c7 >> 6);
    check(32'(u_dev.n_erase), 32'h1);
    ahb(1'b1, REG_CONFIG, 32'h0);
    run_op(OP_ERASE);
    check({24'h0, rd[7:0]}, 32'h60);
    check(32'(u_dev.n_erase), 32'h1);
    ahb(1'b1, REG_CONFIG, 32'h1);
    $display("erase test done");
  endtask : t_erase

  task automatic t_copy;
    ahb(1'b1, REG_ADDR, 32'h0101_0000);
    run_op(OP_COPY_RD);
    check(32'(u_dev.n_copy), 32'h1);
    ahb(1'b1, REG_ADDR, 32'h0000_0123);
    ahb(1'b1, REG_DATA, 32'h5a);
    run_op(OP_DATA_IN);
    check({24'h0, u_dev.data_q}, 32'h5a);
    ahb(1'b1, REG_ADDR, 32'h0202_0000);
    run_op(OP_COPY_PG);
    check(32'(u_dev.n_prog), 32'h1);
    check({16'h0, u_dev.row_q}, 32'h0202);
    check(32'(u_dev.n_bad), 32'h0);
    check({24'h0, rd[7:0]}, 32'he0);
    $display("copy test done");
  endtask : t_copy

  task automatic t_status_reset;
    run_op(OP_STATUS);
    check({31'h0, u_dev.stat_mode}, 32'h1);
    check({24'h0, rd[7:0]}, 32'he0);
    run_op(OP_RESUME);
    check({31'h0, u_dev.stat_mode}, 32'h0);
    ahb(1'b0, REG_CTRL, 32'h0);
    check({29'h0, rd[2:0]}, {29'h0, OP_RESUME});
    run_op(OP_RESET);
    check({30'h0, rd[BIT_ERR:BIT_BUSY]}, 32'h0);
    check({31'h0, rb_low}, 32'h0);
    $display("status and reset test done");
  endtask : t_status_reset

  initial begin
    #400us;
    n_errors++;
    end_of_test;
  end

  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    t_boot;
    t_erase;
    t_copy;
    t_status_reset;
    end_of_test;
  end
endmodule : tb_nand_copy_erase_host
